// ---- design/program_page_and_data_window_map.sv ----
// Program page mapping, data read-only window and data space decode.
// Assumes a CPU core giving the PC and data accesses synchronous to clk_i,
// and a program memory with combinational read data on its window port.
//
// Operation
// R1: Write-only page select at CAh; two low bits pick the lower program page.
// R2: PC bit 11 high always fetches from static page 1.
// R3: PC bit 11 low maps codes 00,01,10,11 to pages 0,1,2,3.
// R4: Page select undefined after reset; no reads or bit operations on it.
// R5: Readout protection option blocks external readout of program memory.
// R6: Data reads at 40h-7Fh return program memory bytes; code drops the read if ext_read_i is high that cycle.
// R7: Window address is window base over the six low data address bits.
// R8: Window moves through program memory in 64-byte steps by writing base.
// R9: Window base sits at C9h; only bits 5-0 position the window.
// R10: Window base is not cleared by reset; software loads it first.
// R11: Window base is write-only; reads and bit operations do not reach it.
// R12: Software avoids changing window base in interrupts or keeps a RAM image.
// R13: Data addresses 00h-3Fh decode as a banked 64-byte region.
// R14: Data space also holds 60 RAM bytes, core and peripheral registers.
// R15: X 80h, Y 81h, V 82h, W 83h, RAM 84h-BFh, accumulator FFh.
// R16: Hardware stack of six 12-bit return address entries.
// R17: Static page sits at 0800h-0FFFh and also as lower page 1.
// R18: Page select is untouched by interrupts, calls and returns.
// R19: Program space is addressed by a 12-bit program counter.
// R20: Unused bits of page select and window base are ignored.
`timescale 1ns/1ps
module program_page_and_data_window_map (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic [11:0]                  pc_i,
  input  wire logic [7:0]                   data_addr_i,
  input  wire logic                         data_rd_i,
  input  wire logic                         data_wr_i,
  input  wire logic                         data_bit_op_i,
  input  wire logic [7:0]                   data_wdata_i,
  output logic      [7:0]                   data_rdata_o,
  output logic                              data_rvalid_o,
  output program_map_pkg::region_t          region_o,
  output logic      [5:0]                   bank_addr_o,
  output logic      [5:0]                   ram_addr_o,
  output logic      [12:0]                  prog_fetch_addr_o,
  output logic      [12:0]                  prog_win_addr_o,
  input  wire logic [7:0]                   prog_win_data_i,
  input  wire logic                         readout_protect_i,
  input  wire logic                         ext_read_i,
  input  wire logic [12:0]                  ext_read_addr_i,
  output logic      [7:0]                   ext_read_data_o,
  output logic                              ext_read_valid_o,
  output logic                              ext_read_blocked_o,
  input  wire logic                         stack_push_i,
  input  wire logic                         stack_pop_i,
  input  wire logic [11:0]                  stack_push_addr_i,
  output logic      [11:0]                  stack_top_o,
  output logic                              page_loaded_o,
  output logic                              window_loaded_o
);

  // ---------------------------------------------------------------------
  // Write-only registers
  // ---------------------------------------------------------------------
  logic       access;
  logic       page_wr;
  logic       win_wr;
  logic [1:0] page_code_raw;
  logic [1:0] page_code;
  logic [5:0] win_base;
  logic       page_loaded;
  logic       win_loaded;

  assign access  = data_wr_i && !data_bit_op_i;
  assign page_wr = access && (data_addr_i == program_map_pkg::ADDR_PAGE_SEL); // R1 R4
  assign win_wr  = access && (data_addr_i == program_map_pkg::ADDR_WIN_BASE); // R9 R11

  write_only_reg #(
    .W (program_map_pkg::PAGE_CODE_W)
  ) u_page_select (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .wr_i     (page_wr),
    .wdata_i  (data_wdata_i),
    .value_o  (page_code_raw),
    .loaded_o (page_loaded)
  );

  write_only_reg #(
    .W (program_map_pkg::WIN_BASE_W)
  ) u_window_base (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .wr_i     (win_wr),
    .wdata_i  (data_wdata_i),
    .value_o  (win_base),
    .loaded_o (win_loaded)
  );

  // Unloaded page code is forced to page 0 so the fetch address never shows unknowns
  assign page_code = page_loaded ? page_code_raw : program_map_pkg::PAGE_CODE_DEFAULT; // R4

  // ---------------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------------
  return_stack #(
    .DEPTH (program_map_pkg::STACK_DEPTH),
    .W     (program_map_pkg::STACK_W)
  ) u_stack (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .push_i      (stack_push_i),
    .pop_i       (stack_pop_i),
    .push_data_i (stack_push_addr_i),
    .top_o       (stack_top_o)
  );

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  logic                      in_bank;
  logic                      in_win;
  logic                      in_ram;
  logic                      win_hit;
  logic                      wo_hit;
  program_map_pkg::region_t  dec_region;

  assign in_bank = data_addr_i <= program_map_pkg::ADDR_BANK_HI; // R13
  assign in_win  = (data_addr_i >= program_map_pkg::ADDR_WIN_LO) &&
                   (data_addr_i <= program_map_pkg::ADDR_WIN_HI);
  assign in_ram  = (data_addr_i >= program_map_pkg::ADDR_RAM_LO) &&
                   (data_addr_i <= program_map_pkg::ADDR_RAM_HI); // R14
  assign win_hit = data_rd_i && in_win && !ext_read_i; // R6
  assign wo_hit  = data_rd_i && ((data_addr_i == program_map_pkg::ADDR_PAGE_SEL) ||
                                 (data_addr_i == program_map_pkg::ADDR_WIN_BASE)); // R11

  always_comb begin
    dec_region = program_map_pkg::RGN_PERIPH;
    if (!(data_rd_i || data_wr_i)) begin
      dec_region = program_map_pkg::RGN_NONE;
    end else if (in_bank) begin
      dec_region = program_map_pkg::RGN_BANK; // R13
    end else if (in_win) begin
      dec_region = program_map_pkg::RGN_WINDOW;
    end else if (in_ram) begin
      dec_region = program_map_pkg::RGN_RAM; // R15
    end else begin
      case (data_addr_i)
        program_map_pkg::ADDR_X:        dec_region = program_map_pkg::RGN_X; // R15
        program_map_pkg::ADDR_Y:        dec_region = program_map_pkg::RGN_Y;
        program_map_pkg::ADDR_V:        dec_region = program_map_pkg::RGN_V;
        program_map_pkg::ADDR_W:        dec_region = program_map_pkg::RGN_W;
        program_map_pkg::ADDR_ACC:      dec_region = program_map_pkg::RGN_ACC;
        program_map_pkg::ADDR_PAGE_SEL: dec_region = program_map_pkg::RGN_WOREG;
        program_map_pkg::ADDR_WIN_BASE: dec_region = program_map_pkg::RGN_WOREG;
        default:                        dec_region = program_map_pkg::RGN_PERIPH;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Address and read pipeline
  // ---------------------------------------------------------------------
  logic [12:0]              fetch_addr;
  logic [12:0]              next_fetch_addr;
  logic [12:0]              win_addr;
  logic [12:0]              next_win_addr;
  logic                     win_pend;
  logic                     next_win_pend;
  logic                     wo_pend;
  logic                     next_wo_pend;
  logic                     ext_pend;
  logic                     next_ext_pend;
  logic                     ext_prot;
  logic                     next_ext_prot;
  logic [7:0]               rdata;
  logic [7:0]               next_rdata;
  logic                     rvalid;
  logic                     next_rvalid;
  logic [7:0]               ext_data;
  logic [7:0]               next_ext_data;
  logic                     ext_valid;
  logic                     next_ext_valid;
  logic                     ext_blocked;
  logic                     next_ext_blocked;
  program_map_pkg::region_t region;
  program_map_pkg::region_t next_region;
  logic [5:0]               bank_addr;
  logic [5:0]               next_bank_addr;
  logic [5:0]               ram_addr;
  logic [5:0]               next_ram_addr;
  logic [7:0]               ram_ofs;

  assign ram_ofs = data_addr_i - program_map_pkg::ADDR_RAM_LO;

  always_comb begin
    // PC is 12 bits; bit 11 chooses static page or selected page
    if (pc_i[program_map_pkg::PC_PAGE_BIT]) begin
      next_fetch_addr = {program_map_pkg::STATIC_PAGE, pc_i[10:0]}; // R2 R17 R19
    end else begin
      next_fetch_addr = {page_code, pc_i[10:0]}; // R3 R17 R18
    end
    next_win_addr    = win_addr;
    next_win_pend    = win_hit;
    next_wo_pend     = wo_hit && !win_hit;
    next_ext_pend    = ext_read_i;
    next_ext_prot    = readout_protect_i;
    next_rdata       = rdata;
    next_rvalid      = 1'b0;
    next_ext_data    = ext_data;
    next_ext_valid   = 1'b0;
    next_ext_blocked = ext_blocked;
    next_region      = dec_region;
    next_bank_addr   = bank_addr;
    next_ram_addr    = ram_addr;
    if (ext_read_i) begin
      next_win_addr = ext_read_addr_i;
    end else if (win_hit) begin
      next_win_addr = {1'b0, win_base, data_addr_i[5:0]}; // R7 R8 R10
    end
    if (in_bank && (data_rd_i || data_wr_i)) begin
      next_bank_addr = data_addr_i[5:0];
    end
    if (in_ram && (data_rd_i || data_wr_i)) begin
      next_ram_addr = ram_ofs[5:0];
    end
    if (win_pend) begin
      next_rdata  = prog_win_data_i; // R6
      next_rvalid = 1'b1;
    end else if (wo_pend) begin
      next_rdata  = program_map_pkg::WO_READ_VALUE; // R4 R11
      next_rvalid = 1'b1;
    end
    if (ext_pend) begin
      next_ext_data    = ext_prot ? program_map_pkg::PROTECT_VALUE : prog_win_data_i; // R5
      next_ext_valid   = 1'b1;
      next_ext_blocked = ext_prot;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch_addr  <= '0;
      win_addr    <= '0;
      win_pend    <= 1'b0;
      wo_pend     <= 1'b0;
      ext_pend    <= 1'b0;
      ext_prot    <= 1'b0;
      rdata       <= '0;
      rvalid      <= 1'b0;
      ext_data    <= '0;
      ext_valid   <= 1'b0;
      ext_blocked <= 1'b0;
      region      <= program_map_pkg::RGN_NONE;
      bank_addr   <= '0;
      ram_addr    <= '0;
    end else begin
      fetch_addr  <= next_fetch_addr;
      win_addr    <= next_win_addr;
      win_pend    <= next_win_pend;
      wo_pend     <= next_wo_pend;
      ext_pend    <= next_ext_pend;
      ext_prot    <= next_ext_prot;
      rdata       <= next_rdata;
      rvalid      <= next_rvalid;
      ext_data    <= next_ext_data;
      ext_valid   <= next_ext_valid;
      ext_blocked <= next_ext_blocked;
      region      <= next_region;
      bank_addr   <= next_bank_addr;
      ram_addr    <= next_ram_addr;
    end
  end

  assign prog_fetch_addr_o  = fetch_addr;
  assign prog_win_addr_o    = win_addr;
  assign data_rdata_o       = rdata;
  assign data_rvalid_o      = rvalid;
  assign ext_read_data_o    = ext_data;
  assign ext_read_valid_o   = ext_valid;
  assign ext_read_blocked_o = ext_blocked;
  assign region_o           = region;
  assign bank_addr_o        = bank_addr;
  assign ram_addr_o         = ram_addr;
  assign page_loaded_o      = page_loaded;
  assign window_loaded_o    = win_loaded;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_static_page;
    pc_i[11] |=> prog_fetch_addr_o == {2'h1, $past(pc_i[10:0])};
  endproperty
  a_static_page: assert property (p_static_page) else $error("static page not fetched"); // R2

  property p_lower_page;
    (!pc_i[11] && page_loaded) |=> prog_fetch_addr_o[12:11] == $past(page_code_raw);
  endproperty
  a_lower_page: assert property (p_lower_page) else $error("lower page mismatch"); // R3

  property p_page_write;
    page_wr ##1 !pc_i[11] |=> prog_fetch_addr_o[12:11] == $past(data_wdata_i[1:0], 2);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write not applied"); // R1

  property p_bit_op_ignored;
    (data_wr_i && data_bit_op_i && !page_wr) |=> $stable(page_code_raw);
  endproperty
  a_bit_op_ignored: assert property (p_bit_op_ignored) else $error("bit op changed page"); // R4

  property p_win_addr;
    win_hit |=> prog_win_addr_o == {1'b0, $past(win_base), $past(data_addr_i[5:0])};
  endproperty
  a_win_addr: assert property (p_win_addr) else $error("window address wrong"); // R7

  property p_win_data;
    win_hit |=> ##1 (data_rvalid_o && data_rdata_o == $past(prog_win_data_i));
  endproperty
  a_win_data: assert property (p_win_data) else $error("window data not returned"); // R6

  property p_wo_read;
    (wo_hit && !ext_read_i) |-> ##2 (data_rvalid_o && data_rdata_o == 8'h00);
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read leaked"); // R11

  property p_protect;
    (ext_read_i && readout_protect_i) |-> ##2 (ext_read_valid_o && ext_read_blocked_o && ext_read_data_o == 8'h00);
  endproperty
  a_protect: assert property (p_protect) else $error("protected readout not blocked"); // R5

  property p_ram_decode;
    (data_rd_i && in_ram) |=> (region_o == program_map_pkg::RGN_RAM) &&
                              (ram_addr_o == $past(data_addr_i[5:0]) - 6'h04);
  endproperty
  a_ram_decode: assert property (p_ram_decode) else $error("RAM decode wrong"); // R15

  property p_bank_decode;
    (data_rd_i && in_bank) |=> (region_o == program_map_pkg::RGN_BANK) && (bank_addr_o == $past(data_addr_i[5:0]));
  endproperty
  a_bank_decode: assert property (p_bank_decode) else $error("bank decode wrong"); // R13

  c_win_read: cover property (win_hit ##2 data_rvalid_o);
  c_page_switch: cover property (page_wr ##1 !pc_i[11] ##1 prog_fetch_addr_o[12:11] == 2'h3);
  c_protected: cover property (ext_read_i && readout_protect_i);
  c_stack_full: cover property (stack_push_i [*6]);

endmodule

// ---- include/program_map_pkg.sv ----
// Constants and types for the program page and data window address map.
// Assumes an 8-bit data space and a 12-bit program counter in the CPU core.
package program_map_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int PC_W        = 12;
  localparam int PROG_ADDR_W = 13;
  localparam int PAGE_OFS_W  = 11;
  localparam int PC_PAGE_BIT = 11;
  localparam int DATA_W      = 8;
  localparam int DADDR_W     = 8;
  localparam int PAGE_CODE_W = 2;
  localparam int WIN_BASE_W  = 6;
  localparam int WIN_OFS_W   = 6;
  localparam int BANK_OFS_W  = 6;
  localparam int RAM_OFS_W   = 6;
  localparam int STACK_DEPTH = 6;
  localparam int STACK_W     = 12;

  // ---------------------------------------------------------------------
  // Data space map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_BANK_LO  = 8'h00;
  localparam logic [7:0] ADDR_BANK_HI  = 8'h3f;
  localparam logic [7:0] ADDR_WIN_LO   = 8'h40;
  localparam logic [7:0] ADDR_WIN_HI   = 8'h7f;
  localparam logic [7:0] ADDR_X        = 8'h80;
  localparam logic [7:0] ADDR_Y        = 8'h81;
  localparam logic [7:0] ADDR_V        = 8'h82;
  localparam logic [7:0] ADDR_W        = 8'h83;
  localparam logic [7:0] ADDR_RAM_LO   = 8'h84;
  localparam logic [7:0] ADDR_RAM_HI   = 8'hbf;
  localparam logic [7:0] ADDR_WIN_BASE = 8'hc9;
  localparam logic [7:0] ADDR_PAGE_SEL = 8'hca;
  localparam logic [7:0] ADDR_ACC      = 8'hff;

  // ---------------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------------
  localparam logic [1:0] STATIC_PAGE       = 2'h1;
  localparam logic [1:0] PAGE_CODE_DEFAULT = 2'h0;
  localparam logic [7:0] WO_READ_VALUE     = 8'h00;
  localparam logic [7:0] PROTECT_VALUE     = 8'h00;

  typedef enum logic [3:0] {
    RGN_NONE,
    RGN_BANK,
    RGN_WINDOW,
    RGN_X,
    RGN_Y,
    RGN_V,
    RGN_W,
    RGN_RAM,
    RGN_WOREG,
    RGN_PERIPH,
    RGN_ACC
  } region_t;

endpackage

// ---- design/write_only_reg.sv ----
// Write-only register that keeps only its used low bits.
// Assumes the writer gives a one-cycle write strobe; contents are not reset.
`timescale 1ns/1ps
module write_only_reg #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         wr_i,
  input  wire logic [7:0]   wdata_i,
  output logic      [W-1:0] value_o,
  output logic              loaded_o
);

  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  logic [W-1:0] value;
  logic [W-1:0] next_value;
  logic         loaded;
  logic         next_loaded;

  always_comb begin
    next_value  = value;
    next_loaded = loaded;
    if (wr_i) begin
      next_value  = wdata_i[W-1:0]; // R20
      next_loaded = 1'b1;
    end
  end

  // Contents survive reset
  always_ff @(posedge clk_i) begin
    value <= next_value;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loaded <= 1'b0;
    end else begin
      loaded <= next_loaded;
    end
  end

  assign value_o  = value;
  assign loaded_o = loaded;

endmodule

// ---- design/return_stack.sv ----
// Hardware return-address stack of fixed depth.
// Assumes push and pop are one-cycle strobes; overflow drops the oldest entry.
`timescale 1ns/1ps
module return_stack #(
  parameter int DEPTH = 6,
  parameter int W     = 12
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         push_i,
  input  wire logic         pop_i,
  input  wire logic [W-1:0] push_data_i,
  output logic      [W-1:0] top_o
);

  // ---------------------------------------------------------------------
  // Entries
  // ---------------------------------------------------------------------
  logic [W-1:0] entry [DEPTH];
  logic [W-1:0] next_entry [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_entry[i] = entry[i];
    end
    if (push_i && pop_i) begin
      next_entry[0] = push_data_i;
    end else if (push_i) begin
      next_entry[0] = push_data_i; // R16
      for (int i = 1; i < DEPTH; i++) begin
        next_entry[i] = entry[i-1];
      end
    end else if (pop_i) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_entry[i] = entry[i+1]; // R16
      end
      next_entry[DEPTH-1] = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        entry[i] <= next_entry[i];
      end
    end
  end

  assign top_o = entry[0];

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_push_top;
    @(posedge clk_i) disable iff (!rst_n_i)
    push_i |=> top_o == $past(push_data_i);
  endproperty
  a_push_top: assert property (p_push_top) else $error("stack top not pushed value"); // R16

  property p_pop_top;
    @(posedge clk_i) disable iff (!rst_n_i)
    (pop_i && !push_i) |=> top_o == $past(entry[1]);
  endproperty
  a_pop_top: assert property (p_pop_top) else $error("stack pop did not expose next entry"); // R16

endmodule

// ---- tb/prog_mem_model.sv ----
// Program memory model behind the window and readout port.
// Assumes combinational reads; each byte is a fixed pattern of its address.
`timescale 1ns/1ps
module prog_mem_model (
  input  wire logic [12:0] addr_i,
  output logic      [7:0]  data_o
);
  assign data_o = addr_i[7:0] ^ {3'h0, addr_i[12:8]} ^ 8'h5a;
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the program page and data window map.
// Assumes the memory model on the window port; inputs change at falling edges.
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 0, rst_n_i = 0, data_rd_i = 0, data_wr_i = 0, data_bit_op_i = 0;
  logic        readout_protect_i = 0, ext_read_i = 0, stack_push_i = 0, stack_pop_i = 0;
  logic [11:0] pc_i = '0, stack_push_addr_i = '0, stack_top_o;
  logic [7:0]  data_addr_i = '0, data_wdata_i = '0, data_rdata_o, prog_win_data_i, ext_read_data_o;
  logic [12:0] ext_read_addr_i = '0, prog_fetch_addr_o, prog_win_addr_o;
  logic [5:0]  bank_addr_o, ram_addr_o;
  logic        data_rvalid_o, ext_read_valid_o, ext_read_blocked_o, page_loaded_o, window_loaded_o;
  program_map_pkg::region_t region_o;
  int          err_count = 0, comparisons = 0;
  logic [7:0]  bases [3] = '{8'hc0, 8'h3f, 8'h15};
  logic [7:0]  dec_a [10] = '{8'h00, 8'h3f, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'hbf, 8'hff, 8'hd0};
  program_map_pkg::region_t dec_r [10] = '{program_map_pkg::RGN_BANK, program_map_pkg::RGN_BANK,
    program_map_pkg::RGN_X, program_map_pkg::RGN_Y, program_map_pkg::RGN_V, program_map_pkg::RGN_W,
    program_map_pkg::RGN_RAM, program_map_pkg::RGN_RAM, program_map_pkg::RGN_ACC, program_map_pkg::RGN_PERIPH};

  program_page_and_data_window_map dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pc_i(pc_i), .data_addr_i(data_addr_i), .data_rd_i(data_rd_i),
    .data_wr_i(data_wr_i), .data_bit_op_i(data_bit_op_i), .data_wdata_i(data_wdata_i),
    .data_rdata_o(data_rdata_o), .data_rvalid_o(data_rvalid_o), .region_o(region_o),
    .bank_addr_o(bank_addr_o), .ram_addr_o(ram_addr_o), .prog_fetch_addr_o(prog_fetch_addr_o),
    .prog_win_addr_o(prog_win_addr_o), .prog_win_data_i(prog_win_data_i),
    .readout_protect_i(readout_protect_i), .ext_read_i(ext_read_i), .ext_read_addr_i(ext_read_addr_i),
    .ext_read_data_o(ext_read_data_o), .ext_read_valid_o(ext_read_valid_o),
    .ext_read_blocked_o(ext_read_blocked_o), .stack_push_i(stack_push_i), .stack_pop_i(stack_pop_i),
    .stack_push_addr_i(stack_push_addr_i), .stack_top_o(stack_top_o), .page_loaded_o(page_loaded_o),
    .window_loaded_o(window_loaded_o));
  prog_mem_model mem_model (.addr_i(prog_win_addr_o), .data_o(prog_win_data_i));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [7:0] mem(input logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h5a;
  endfunction
  function automatic logic [12:0] win(input logic [7:0] b, input logic [7:0] o);
    return {1'b0, b[5:0], o[5:0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_rgn(input program_map_pkg::region_t got, input program_map_pkg::region_t exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: region got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bit_op);
    data_addr_i = a;
    data_wdata_i = d;
    data_bit_op_i = bit_op;
    data_wr_i = 1;
    @(negedge clk_i);
    data_wr_i = 0;
    data_bit_op_i = 0;
  endtask
  task automatic fetch(input logic [11:0] pc, input logic [12:0] exp);
    pc_i = pc;
    @(negedge clk_i);
    chk(prog_fetch_addr_o, exp, "fetch address");
  endtask
  task automatic rd(input logic [7:0] a, input program_map_pkg::region_t r, input logic [12:0] wa);
    data_addr_i = a;
    data_rd_i = 1;
    @(negedge clk_i);
    data_rd_i = 0;
    chk_rgn(region_o, r);
    if (r == program_map_pkg::RGN_WINDOW) chk(prog_win_addr_o, wa, "window address");
    @(negedge clk_i);
    if (r inside {program_map_pkg::RGN_WINDOW, program_map_pkg::RGN_WOREG}) begin
      chk(data_rvalid_o, 1, "read valid");
      chk(data_rdata_o, (r == program_map_pkg::RGN_WINDOW) ? mem(wa) : 8'h00, "read data");
    end else begin
      chk(data_rvalid_o, 0, "read valid");
    end
  endtask
  task automatic ext(input logic [12:0] a, input logic prot);
    readout_protect_i = prot;
    ext_read_addr_i = a;
    ext_read_i = 1;
    @(negedge clk_i);
    ext_read_i = 0;
    chk(prog_win_addr_o, a, "readout address");
    @(negedge clk_i);
    chk(ext_read_valid_o, 1, "readout valid");
    chk(ext_read_data_o, prot ? 8'h00 : mem(a), "readout data");
    chk(ext_read_blocked_o, prot, "readout blocked");
  endtask
  task automatic stack_op(input logic push, input logic [11:0] v, input logic [11:0] exp);
    stack_push_addr_i = v;
    stack_push_i = push;
    stack_pop_i = !push;
    @(negedge clk_i);
    chk(stack_top_o, exp, "stack top");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------------
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #80000;
    err_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    repeat (12) @(negedge clk_i);
    rst_n_i = 1;
    chk(page_loaded_o, 0, "page flag");
    fetch(12'h123, 13'h0123);
    fetch(12'h812, 13'h0812);
    for (int c = 0; c < 4; c++) begin
      wr(8'hca, 8'hfc | 8'(c), 0);
      fetch(12'h4a5, {c[1:0], 11'h4a5});
      fetch(12'hfff, 13'h0fff);
    end
    chk(page_loaded_o, 1, "page flag");
    wr(8'hca, 8'h01, 1);
    fetch(12'h010, 13'h1810);
    rd(8'hca, program_map_pkg::RGN_WOREG, 13'h0);
    rd(8'hc9, program_map_pkg::RGN_WOREG, 13'h0);
    $display("test page select done");
    foreach (bases[i]) begin
      wr(8'hc9, bases[i], 0);
      foreach (dec_a[j]) if (j < 3) rd(8'h40 + 8'(j * 31), program_map_pkg::RGN_WINDOW,
        win(bases[i], 8'h40 + 8'(j * 31)));
    end
    chk(window_loaded_o, 1, "window flag");
    wr(8'hc9, 8'h00, 1);
    rd(8'h40, program_map_pkg::RGN_WINDOW, win(8'h15, 8'h40));
    rst_n_i = 0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1;
    chk(window_loaded_o, 0, "window flag");
    rd(8'h7f, program_map_pkg::RGN_WINDOW, win(8'h15, 8'h7f));
    $display("test data window done");
    foreach (dec_a[k]) begin
      rd(dec_a[k], dec_r[k], 13'h0);
      if (k < 2) chk(bank_addr_o, dec_a[k][5:0], "bank offset");
      if (k > 5 && k < 8) chk(ram_addr_o, dec_a[k] - 8'h84, "ram offset");
    end
    $display("test decode done");
    ext(13'h1abc, 0);
    ext(13'h0fc1, 1);
    $display("test readout done");
    wr(8'hca, 8'h02, 0);
    for (int k = 1; k <= 7; k++) stack_op(1, 12'h111 * 12'(k), 12'h111 * 12'(k));
    for (int k = 6; k >= 1; k--) stack_op(0, 12'h0, (k >= 2) ? 12'h111 * 12'(k) : 12'h0);
    stack_pop_i = 0;
    fetch(12'h010, 13'h1010);
    $display("test stack done");
    report_and_stop();
  end
endmodule
